// ===== rtl/rmf_ctrl.sv
// Reset qualification, host mode entry, fetch strobes and third port pins
// Contract
// - Port bits written one pulled high, readable
// - Third port carries serial, interrupt, timer, strobes
// - Internal execution keeps program strobe high
// - External fetch: two strobes, one skipped on data
// - Reset high two machine cycles resets device
// - Strobe falling during long reset enters host mode
// - Otherwise reset release enters normal operation
// - Lock level four forces internal execution
// - Host mode takes controls from third port
// - Address latch at one sixth, skip on data
`timescale 1ns/100ps
module rmf_ctrl (
    input  wire logic       CLK_IN,
    input  wire logic       RST_IN,
    input  wire logic       RESET_PIN_IN,
    input  wire logic       PROGRAM_STORE_READ_STROBE_N_PIN_IN,
    input  wire logic       EXT_ACCESS_SEL_N_IN,
    input  wire logic       LOCK_LEVEL4_IN,
    input  wire logic       DATA_CYCLE_IN,
    input  wire logic [7:0] PORT_LATCH_IN,
    input  wire logic       TXD_IN,
    input  wire logic       DATA_WR_N_IN,
    input  wire logic       DATA_RD_N_IN,
    input  wire logic [7:0] THIRD_GENERAL_PORT_IN,
    output logic [7:0]      THIRD_GENERAL_PORT_OUT,
    output logic [7:0]      THIRD_GENERAL_PORT_OE_OUT,
    output logic [7:0]      THIRD_GENERAL_PORT_PULLUP_OUT,
    output logic [7:0]      PORT_READ_OUT,
    output logic            RXD_OUT,
    output logic            EXT_INTERRUPT_ZERO_N_OUT,
    output logic            EXT_INTERRUPT_ONE_N_OUT,
    output logic            TIMER_ZERO_COUNT_OUT,
    output logic            TIMER_ONE_COUNT_OUT,
    output logic            PROGRAM_STORE_READ_STROBE_N_OUT,
    output logic            PROGRAM_STORE_READ_STROBE_OE_OUT,
    output logic            ALE_OUT,
    output logic            DEVICE_RESET_OUT,
    output logic            HOST_MODE_OUT,
    output logic            EXT_FETCH_OUT,
    output logic [7:0]      HOST_CTRL_OUT
);
    import rmf_pkg::*;

    typedef struct packed {
        logic [2:0] rst_s;
        logic [2:0] program_store_read_strobe_n_s;
        logic [2:0] ea_s;
        logic [7:0] prt_s0;
        logic [7:0] prt_s1;
        logic [7:0] prt_s2;
        logic       rst_f;
        logic       program_store_read_strobe_n_f;
        logic       ea_f;
        logic [7:0] prt_f;
        logic [7:0] cnt;
        logic       dev_rst;
        logic       host_arm;
        logic       host;
        logic [3:0] phase;
        logic       data_cyc;
        logic       ext;
        logic       ale;
        logic       program_store_read_strobe_n_o;
        logic       program_store_read_strobe_n_oe;
        logic [7:0] prt_o;
        logic [7:0] prt_oe;
        logic [7:0] hctl;
    } rmf_state_t;

    rmf_state_t st_q;
    rmf_state_t st_d;
    logic       program_store_read_strobe_n_fall;
    logic       ext_now;
    logic [7:0] drive;

    // Falling strobe seen once both late stages agree
    assign program_store_read_strobe_n_fall = st_q.program_store_read_strobe_n_f && (st_q.program_store_read_strobe_n_s[1] == st_q.program_store_read_strobe_n_s[2]) && !st_q.program_store_read_strobe_n_s[2];
    // Lock level four overrides the access select pin
    assign ext_now   = !st_q.ea_f && !LOCK_LEVEL4_IN;

    // Port drive: latch ANDed with alternate outputs; inputs keep latch at one
    always_comb begin
        drive         = PORT_LATCH_IN;
        drive[BIT_TXD] = PORT_LATCH_IN[BIT_TXD] & TXD_IN;
        drive[BIT_WR]  = PORT_LATCH_IN[BIT_WR] & DATA_WR_N_IN;
        drive[BIT_RD]  = PORT_LATCH_IN[BIT_RD] & DATA_RD_N_IN;
    end

    // Next state of the whole block
    always_comb begin
        st_d = st_q;
        // Three stage synchronisers; only stage one feeds stage two
        st_d.rst_s  = {st_q.rst_s[1:0], RESET_PIN_IN};
        st_d.program_store_read_strobe_n_s = {st_q.program_store_read_strobe_n_s[1:0], PROGRAM_STORE_READ_STROBE_N_PIN_IN};
        st_d.ea_s   = {st_q.ea_s[1:0], EXT_ACCESS_SEL_N_IN};
        st_d.prt_s0 = THIRD_GENERAL_PORT_IN;
        st_d.prt_s1 = st_q.prt_s0;
        st_d.prt_s2 = st_q.prt_s1;
        if (st_q.rst_s[1] == st_q.rst_s[2]) begin
            st_d.rst_f = st_q.rst_s[2];
        end
        if (st_q.program_store_read_strobe_n_s[1] == st_q.program_store_read_strobe_n_s[2]) begin
            st_d.program_store_read_strobe_n_f = st_q.program_store_read_strobe_n_s[2];
        end
        if (st_q.ea_s[1] == st_q.ea_s[2]) begin
            st_d.ea_f = st_q.ea_s[2];
        end
        for (int i = 0; i < 8; i++) begin
            if (st_q.prt_s1[i] == st_q.prt_s2[i]) begin
                st_d.prt_f[i] = st_q.prt_s2[i];
            end
        end
        // Reset duration count saturates so long holds never wrap
        if (st_q.rst_f) begin
            if (st_q.cnt != CNT_MAX) begin
                st_d.cnt = st_q.cnt + 8'h01;
            end
            st_d.dev_rst = (st_q.cnt >= 8'(RST_MIN_CLKS - 1));
            if (program_store_read_strobe_n_fall && st_q.cnt >= 8'(HOST_MIN_CLKS)) begin
                st_d.host_arm = 1'b1;
            end
        end else begin
            st_d.cnt      = 8'h00;
            st_d.dev_rst  = 1'b0;
            st_d.host_arm = 1'b0;
        end
        // Mode chosen once, at reset release
        if (st_q.rst_f && !st_d.rst_f) begin
            st_d.host = st_q.host_arm;
        end
        // Machine cycle phase; data cycle flag taken for the coming cycle
        if (st_q.dev_rst) begin
            st_d.phase    = 4'h0;
            st_d.data_cyc = 1'b0;
        end else if (st_q.phase == PH_LAST) begin
            st_d.phase    = 4'h0;
            st_d.data_cyc = DATA_CYCLE_IN;
        end else begin
            st_d.phase = st_q.phase + 4'h1;
        end
        st_d.ext = ext_now && !st_q.host;
        // Address latch pulses twice per cycle, second dropped on data access
        st_d.ale = !st_q.dev_rst && !st_q.host &&
                   ((st_q.phase == PH_ALE_A) || (st_q.phase == PH_ALE_B && !st_q.data_cyc));
        // Program strobe low only for external fetch
        st_d.program_store_read_strobe_n_o = !(ext_now && !st_q.dev_rst && !st_q.host &&
                        ((st_q.phase == PH_PROGRAM_STORE_READ_STROBE_N_A) ||
                         (st_q.phase == PH_PROGRAM_STORE_READ_STROBE_N_B && !st_q.data_cyc)));
        // Strobe pin released during reset so the host can pull it down
        st_d.program_store_read_strobe_n_oe = !st_q.rst_f && !st_q.host;
        // Port drives low only; pull-up holds ones; host mode frees the pins
        if (st_q.host) begin
            st_d.prt_o  = PORT_RST;
            st_d.prt_oe = 8'h00;
            st_d.hctl   = st_q.prt_f;
        end else begin
            st_d.prt_o  = drive;
            st_d.prt_oe = ~drive;
            st_d.hctl   = 8'h00;
        end
    end

    // Single state register
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            st_q        <= '0;
            st_q.rst_s  <= 3'h0;
            st_q.program_store_read_strobe_n_s <= 3'h7;
            st_q.ea_s   <= 3'h7;
            st_q.prt_s0 <= PORT_RST;
            st_q.prt_s1 <= PORT_RST;
            st_q.prt_s2 <= PORT_RST;
            st_q.program_store_read_strobe_n_f <= 1'b1;
            st_q.ea_f   <= 1'b1;
            st_q.prt_f  <= PORT_RST;
            st_q.program_store_read_strobe_n_o <= 1'b1;
            st_q.prt_o  <= PORT_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // Ports straight from the state register
    assign THIRD_GENERAL_PORT_OUT           = st_q.prt_o;
    assign THIRD_GENERAL_PORT_OE_OUT        = st_q.prt_oe;
    assign THIRD_GENERAL_PORT_PULLUP_OUT    = st_q.prt_o;
    assign PORT_READ_OUT                    = st_q.prt_f;
    assign RXD_OUT                          = st_q.prt_f[BIT_RXD];
    assign EXT_INTERRUPT_ZERO_N_OUT         = st_q.prt_f[BIT_EXT_INTERRUPT_ZERO_N];
    assign EXT_INTERRUPT_ONE_N_OUT          = st_q.prt_f[BIT_EXT_INTERRUPT_ONE_N];
    assign TIMER_ZERO_COUNT_OUT             = st_q.prt_f[BIT_T0];
    assign TIMER_ONE_COUNT_OUT              = st_q.prt_f[BIT_T1];
    assign PROGRAM_STORE_READ_STROBE_N_OUT  = st_q.program_store_read_strobe_n_o;
    assign PROGRAM_STORE_READ_STROBE_OE_OUT = st_q.program_store_read_strobe_n_oe;
    assign ALE_OUT                          = st_q.ale;
    assign DEVICE_RESET_OUT                 = st_q.dev_rst;
    assign HOST_MODE_OUT                    = st_q.host;
    assign EXT_FETCH_OUT                    = st_q.ext;
    assign HOST_CTRL_OUT                    = st_q.hctl;

    // Checks on the registered behaviour
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);

    sequence s_rst_release;
        st_q.rst_f ##1 !st_q.rst_f;
    endsequence

    sequence s_int_fetch;
        !ext_now || st_q.host;
    endsequence

    property p_int_high;
        s_int_fetch |=> PROGRAM_STORE_READ_STROBE_N_OUT;
    endproperty
    a_int_high: assert property (p_int_high) else $error("strobe low on internal fetch");

    property p_lock;
        LOCK_LEVEL4_IN |=> PROGRAM_STORE_READ_STROBE_N_OUT && !EXT_FETCH_OUT;
    endproperty
    a_lock: assert property (p_lock) else $error("lock level four did not force internal");

    property p_two_strobes;
        (ext_now && !st_q.host && !st_q.dev_rst && st_q.phase == PH_PROGRAM_STORE_READ_STROBE_N_A)
            |=> !PROGRAM_STORE_READ_STROBE_N_OUT ##1 PROGRAM_STORE_READ_STROBE_N_OUT[*5]
                ##1 (PROGRAM_STORE_READ_STROBE_N_OUT == (st_q.data_cyc || !$past(ext_now) ||
                                                         $past(st_q.host) || $past(st_q.dev_rst)));
    endproperty
    a_two_strobes: assert property (p_two_strobes) else $error("strobe pattern wrong");

    property p_ale;
        (!st_q.dev_rst && !st_q.host && st_q.phase == PH_ALE_B)
            |=> ALE_OUT == !$past(st_q.data_cyc);
    endproperty
    a_ale: assert property (p_ale) else $error("latch strobe skip wrong");

    property p_reset_len;
        // Only a hold that lasts one more clock must qualify; a pin dropping there is not checked
        (st_q.rst_f && st_q.cnt == 8'(RST_MIN_CLKS - 2)) ##1 st_q.rst_f
            |-> !DEVICE_RESET_OUT ##1 DEVICE_RESET_OUT;
    endproperty
    a_reset_len: assert property (p_reset_len) else $error("reset qualified at wrong time");

    property p_host_arm;
        (st_q.rst_f && program_store_read_strobe_n_fall && st_q.cnt >= 8'(HOST_MIN_CLKS)) |=> st_q.host_arm;
    endproperty
    a_host_arm: assert property (p_host_arm) else $error("host entry not armed");

    property p_mode_pick;
        s_rst_release |-> HOST_MODE_OUT == $past(st_q.host_arm);
    endproperty
    a_mode_pick: assert property (p_mode_pick) else $error("mode chosen wrongly at release");

    property p_sync;
        $changed(st_q.rst_f) |-> $past(st_q.rst_s[1] == st_q.rst_s[2]);
    endproperty
    a_sync: assert property (p_sync) else $error("reset level taken before agreement");

    property p_host_port;
        HOST_MODE_OUT |=> THIRD_GENERAL_PORT_OE_OUT == 8'h00 && HOST_CTRL_OUT == $past(st_q.prt_f);
    endproperty
    a_host_port: assert property (p_host_port) else $error("host mode port handling wrong");

    property p_port_drive;
        !HOST_MODE_OUT |=> THIRD_GENERAL_PORT_OUT[BIT_WR] == $past(PORT_LATCH_IN[BIT_WR] & DATA_WR_N_IN)
                           && THIRD_GENERAL_PORT_OE_OUT == ~THIRD_GENERAL_PORT_OUT;
    endproperty
    a_port_drive: assert property (p_port_drive) else $error("port drive wrong");
endmodule

// ===== rtl/rmf_pkg.sv
// Constants for reset, mode entry and fetch strobe control
package rmf_pkg;
    // Machine cycle and its strobe phases
    localparam int        CLKS_PER_MC    = 12;
    localparam int        RST_MIN_MC     = 2;
    localparam int        HOST_MIN_MC    = 10;
    localparam int        RST_MIN_CLKS   = RST_MIN_MC * CLKS_PER_MC;
    localparam int        HOST_MIN_CLKS  = HOST_MIN_MC * CLKS_PER_MC;
    localparam logic [3:0] PH_LAST       = 4'hB;
    localparam logic [3:0] PH_ALE_A      = 4'h0;
    localparam logic [3:0] PH_ALE_B      = 4'h6;
    localparam logic [3:0] PH_PROGRAM_STORE_READ_STROBE_N_A     = 4'h3;
    localparam logic [3:0] PH_PROGRAM_STORE_READ_STROBE_N_B     = 4'h9;
    localparam logic [7:0] CNT_MAX       = 8'hFF;
    // Third port bit positions
    localparam int        BIT_RXD        = 0;
    localparam int        BIT_TXD        = 1;
    localparam int        BIT_EXT_INTERRUPT_ZERO_N       = 2;
    localparam int        BIT_EXT_INTERRUPT_ONE_N       = 3;
    localparam int        BIT_T0         = 4;
    localparam int        BIT_T1         = 5;
    localparam int        BIT_WR         = 6;
    localparam int        BIT_RD         = 7;
    // Reset values
    localparam logic [7:0] PORT_RST      = 8'hFF;
endpackage

// ===== tb/rmf_far_model.sv
// Far-side model: reset source, host programmer and port pin loads
`timescale 1ns/100ps
module rmf_far_model (
    input  wire logic       clk_in,
    input  wire logic       rst_req_in,
    input  wire logic       program_store_read_strobe_n_pull_in,
    input  wire logic [7:0] low_mask_in,
    input  wire logic       strobe_n_in,
    input  wire logic       strobe_oe_in,
    input  wire logic [7:0] port_oe_in,
    output logic            reset_pin_out,
    output logic            program_store_read_strobe_n_pin_out,
    output logic [7:0]      port_pin_out
);
    // Reset pin follows the request; the caller sets how long it stays high
    always_ff @(posedge clk_in) begin
        reset_pin_out <= rst_req_in;
    end
    // Device drive wins, else the programmer pulls low, else the pull-up holds high
    assign program_store_read_strobe_n_pin_out = strobe_oe_in ? strobe_n_in : ~program_store_read_strobe_n_pull_in;
    // Either side may pull a port pin low; released pins float back high
    assign port_pin_out = ~(port_oe_in | low_mask_in);
endmodule

// ===== tb/tb_top.sv
// Self-checking bench for reset, mode entry, fetch strobes and third port
`timescale 1ns/100ps
module tb_top;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic       ea_n = 1'b1, lock = 1'b0, dcyc = 1'b0;
    logic       txd = 1'b1, wr_n = 1'b1, rd_n = 1'b1;
    logic       rst_req = 1'b0, pull = 1'b0;
    logic [7:0] latch = 8'hFF, mask = 8'h00;
    logic [7:0] p_out, p_oe, p_pu, p_rd, h_ctl, pins;
    logic       rst_pin, ps_pin, ps_n, ps_oe, ale, dev_rst, host, xf;
    logic       rxd, i0, i1, t0c, t1c;
    int         error_cnt = 0;
    int         cmp_count = 0;
    // Free-running oscillator at 8 ns
    always #4 clk = ~clk;
    rmf_far_model rmf_far_model_inst (.clk_in(clk), .rst_req_in(rst_req), .program_store_read_strobe_n_pull_in(pull),
        .low_mask_in(mask), .strobe_n_in(ps_n), .strobe_oe_in(ps_oe), .port_oe_in(p_oe),
        .reset_pin_out(rst_pin), .program_store_read_strobe_n_pin_out(ps_pin), .port_pin_out(pins));
    rmf_ctrl rmf_ctrl_inst (.CLK_IN(clk), .RST_IN(rst), .RESET_PIN_IN(rst_pin), .PROGRAM_STORE_READ_STROBE_N_PIN_IN(ps_pin),
        .EXT_ACCESS_SEL_N_IN(ea_n), .LOCK_LEVEL4_IN(lock), .DATA_CYCLE_IN(dcyc), .PORT_LATCH_IN(latch),
        .TXD_IN(txd), .DATA_WR_N_IN(wr_n), .DATA_RD_N_IN(rd_n), .THIRD_GENERAL_PORT_IN(pins),
        .THIRD_GENERAL_PORT_OUT(p_out), .THIRD_GENERAL_PORT_OE_OUT(p_oe),
        .THIRD_GENERAL_PORT_PULLUP_OUT(p_pu), .PORT_READ_OUT(p_rd), .RXD_OUT(rxd),
        .EXT_INTERRUPT_ZERO_N_OUT(i0), .EXT_INTERRUPT_ONE_N_OUT(i1), .TIMER_ZERO_COUNT_OUT(t0c),
        .TIMER_ONE_COUNT_OUT(t1c), .PROGRAM_STORE_READ_STROBE_N_OUT(ps_n),
        .PROGRAM_STORE_READ_STROBE_OE_OUT(ps_oe), .ALE_OUT(ale), .DEVICE_RESET_OUT(dev_rst),
        .HOST_MODE_OUT(host), .EXT_FETCH_OUT(xf), .HOST_CTRL_OUT(h_ctl));
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Counts one-clock strobe pulses over two machine cycles, any phase
    task automatic count24(output logic [7:0] np, output logic [7:0] na);
        np = 8'h00;
        na = 8'h00;
        repeat (24) begin
            @(negedge clk);
            np = np + {7'h00, ~ps_n};
            na = na + {7'h00, ale};
        end
    endtask
    task automatic t_reset();
        rst_req <= 1'b1;
        tick(12);
        rst_req <= 1'b0;
        tick(40);
        chk("short_pulse", 8'h00, {7'h00, dev_rst});
        rst_req <= 1'b1;
        tick(20);
        chk("early_reset", 8'h00, {7'h00, dev_rst});
        tick(20);
        chk("full_reset", 8'h01, {7'h00, dev_rst});
        rst_req <= 1'b0;
        tick(12);
        chk("reset_gone", 8'h00, {7'h00, dev_rst});
        chk("normal_mode", 8'h00, {7'h00, host});
        chk("strobe_driven", 8'h01, {7'h00, ps_oe});
    endtask
    task automatic fetch(input logic e, input logic l, input logic d, input logic [7:0] ep,
                         input logic [7:0] ea, input logic ex);
        logic [7:0] np, na;
        ea_n <= e;
        lock <= l;
        dcyc <= d;
        tick(30);
        count24(np, na);
        chk("program_store_read_strobe_n_pulses", ep, np);
        chk("ale_pulses", ea, na);
        chk("ext_fetch", {7'h00, ex}, {7'h00, xf});
        @(posedge clk);
    endtask
    task automatic t_host();
        rst_req <= 1'b1;
        tick(140);
        pull <= 1'b1;
        tick(6);
        pull <= 1'b0;
        mask <= 8'h5A;
        tick(6);
        rst_req <= 1'b0;
        tick(12);
        chk("host_mode", 8'h01, {7'h00, host});
        chk("host_ctrl", 8'hA5, h_ctl);
        chk("host_port_oe", 8'h00, p_oe);
        chk("host_strobe_oe", 8'h00, {7'h00, ps_oe});
        fetch(1'b0, 1'b0, 1'b0, 8'h00, 8'h00, 1'b0);
        mask <= 8'h00;
        rst_req <= 1'b1;
        tick(40);
        rst_req <= 1'b0;
        tick(12);
        chk("left_host", 8'h00, {7'h00, host});
    endtask
    task automatic port_case(input logic [7:0] l, input logic tx, input logic w, input logic r,
                             input logic [7:0] m);
        logic [7:0] eo, ep;
        eo = l & {r, w, 4'hF, tx, 1'b1};
        ep = eo & ~m;
        latch <= l;
        txd <= tx;
        wr_n <= w;
        rd_n <= r;
        mask <= m;
        tick(8);
        chk("port_out", eo, p_out);
        chk("port_pullup", eo, p_pu);
        chk("port_oe", ~eo, p_oe);
        chk("port_read", ep, p_rd);
        chk("alt_inputs", {3'h0, ep[5], ep[4], ep[3], ep[2], ep[0]}, {3'h0, t1c, t0c, i1, i0, rxd});
    endtask
    task automatic close_out();
        $display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Main sequence after a five-cycle synchronous reset
    initial begin
        tick(5);
        rst <= 1'b0;
        tick(4);
        t_reset();
        fetch(1'b0, 1'b0, 1'b0, 8'h04, 8'h04, 1'b1);
        fetch(1'b0, 1'b0, 1'b1, 8'h02, 8'h02, 1'b1);
        fetch(1'b0, 1'b1, 1'b0, 8'h00, 8'h04, 1'b0);
        fetch(1'b1, 1'b0, 1'b0, 8'h00, 8'h04, 1'b0);
        t_host();
        port_case(8'hF0, 1'b1, 1'b1, 1'b1, 8'h00);
        port_case(8'hFF, 1'b0, 1'b0, 1'b1, 8'h00);
        port_case(8'hFF, 1'b1, 1'b1, 1'b0, 8'h3D);
        close_out();
    end
    // Watchdog well beyond the roughly 630 cycles the sequence needs
    initial begin
        tick(4000);
        error_cnt++;
        close_out();
    end
endmodule
